// file: adc_regs_cfg.svh
`ifndef ADC_REGS_CFG_SVH
`define ADC_REGS_CFG_SVH

// Frame layout
`define FRAME_BITS        16
`define OPCODE_MSB        15
`define OPCODE_LSB        12
`define ADDR_MSB          11
`define ADDR_LSB          8
`define DATA_MSB          7
`define DATA_LSB          0

// Opcodes
`define OP_WRITE          4'h1
`define OP_READ           4'h2
`define OP_SET_BITS       4'h5
`define OP_CLEAR_BITS     4'h6

// Register offsets
`define ADDR_STATUS_FLAGS 4'h0
`define ADDR_POWER_DOWN   4'h1
`define ADDR_PROTOCOL     4'h2

// Reset values
`define RST_STATUS_FLAGS  8'h00
`define RST_POWER_DOWN    8'h00
`define RST_PROTOCOL      8'h00

// Implemented bit masks
`define MASK_STATUS_FLAGS 8'h06
`define MASK_POWER_DOWN   8'h2B
`define MASK_PROTOCOL     8'h73

// Field positions
`define BIT_WIDE_READ     2
`define BIT_AVG_INTR      1
`define BIT_HALF_REF      5
`define BIT_SECOND_CONV   3
`define BIT_FIRST_CONV    1
`define BIT_INT_REF       0
`define PROTO_MSB         6
`define PROTO_LSB         4
`define BIT_CLK_POL       1
`define BIT_CLK_PHASE     0

`endif

// file: adc_regs_pkg.sv
package adc_regs_pkg;
	typedef logic [7:0]  reg_byte_t;
	typedef logic [3:0]  nibble_t;
	typedef logic [15:0] frame_word_t;
	typedef logic [2:0]  proto_sel_t;
endpackage

// file: link_if.sv
`timescale 1ns/1ps
interface link_if;
	import adc_regs_pkg::*;
	frame_word_t frame_word;
	logic        frame_tgl;
	reg_byte_t   resp;
	logic        cpol;
	logic        cpha;
	modport link (output frame_word, output frame_tgl, input resp, input cpol, input cpha);
	modport core (input frame_word, input frame_tgl, output resp, output cpol, output cpha);
endinterface

// file: toggle_sync.sv
`timescale 1ns/1ps
module toggle_sync
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	// Toggle in, pulse out
	input  wire logic tgl_i,
	output logic      pulse_o
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else if (ce_i)
		begin
			s1 <= tgl_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign pulse_o = s2 ^ s3;
endmodule

// file: serial_link.sv
`timescale 1ns/1ps
module serial_link
	import adc_regs_pkg::*;
(
	// Serial pins
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	input  wire logic sdi_i,
	output logic      sdo_o,
	// Reset
	input  wire logic nrst_i,
	// Core side
	link_if.link      lnk
);
	`include "adc_regs_cfg.svh"

	logic [4:0]  bit_cnt;
	logic [14:0] rx;
	wire         sample_clk;
	wire         last_bit;
	wire  [2:0]  out_idx;
	wire         out_window;

	// Sample edge follows polarity and phase
	assign sample_clk = sclk_i ^ (lnk.cpol ^ lnk.cpha);
	assign last_bit   = (bit_cnt == 5'(`FRAME_BITS - 1));
	assign out_idx    = 3'(4'h8 - bit_cnt[3:0]);
	assign out_window = (bit_cnt >= 5'h01) && (bit_cnt <= 5'h08);

	// Shift in command bits while selected
	always_ff @(posedge sample_clk or posedge cs_n_i)
	begin
		if (cs_n_i)
		begin
			bit_cnt <= 5'h00;
			rx      <= 15'h0000;
		end
		else
		begin
			rx <= {rx[13:0], sdi_i};
			if (bit_cnt != 5'(`FRAME_BITS))
				bit_cnt <= bit_cnt + 5'h01;
		end
	end

	// Completed frame handed over by toggle
	always_ff @(posedge sample_clk or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			lnk.frame_word <= 16'h0000;
			lnk.frame_tgl  <= 1'b0;
		end
		else if (!cs_n_i && last_bit)
		begin
			lnk.frame_word <= {rx, sdi_i};
			lnk.frame_tgl  <= ~lnk.frame_tgl;
		end
	end

	// Previous read answer shifted out MSB first
	always_ff @(negedge sample_clk or posedge cs_n_i)
	begin
		if (cs_n_i)
			sdo_o <= 1'b0;
		else
			sdo_o <= out_window ? lnk.resp[out_idx] : 1'b0;
	end
endmodule

// file: adc_status_power_protocol_regs.sv
`timescale 1ns/1ps
module adc_status_power_protocol_regs
	import adc_regs_pkg::*;
(
	// Core clock, reset, enable
	input  wire logic                    core_clk_i,
	input  wire logic                    nrst_i,
	input  wire logic                    ce_i,
	// Serial link
	input  wire logic                    sclk_i,
	input  wire logic                    cs_n_i,
	input  wire logic                    sdi_i,
	output logic                         sdo_o,
	// Converter events
	input  wire logic                    wide_read_zone2_i,
	input  wire logic                    averaging_busy_i,
	// Status flags
	output logic                         wide_read_late_flag_o,
	output logic                         averaging_interrupted_flag_o,
	// Power-down controls
	output logic                         half_reference_off_o,
	output logic                         second_converter_off_o,
	output logic                         first_converter_off_o,
	output logic                         internal_reference_off_o,
	// Readout protocol
	output adc_regs_pkg::proto_sel_t     readout_protocol_select_o,
	output logic                         serial_clock_polarity_o,
	output logic                         serial_clock_phase_o,
	output logic                         retimed_clock_protocol_o,
	output logic                         double_data_rate_o,
	output logic                         parallel_byte_o
);
	import adc_regs_pkg::*;
	`include "adc_regs_cfg.svh"

	link_if lnk ();

	logic        rst_s1;
	logic        rst_n;
	logic        cs_s1;
	logic        cs_s2;
	logic        cs_s3;
	reg_byte_t   status_flags;
	reg_byte_t   power_down;
	reg_byte_t   protocol;
	reg_byte_t   resp;
	logic        rt_q;
	logic        ddr_q;
	logic        par_q;
	wire         frame_pulse;
	nibble_t     opcode;
	nibble_t     addr;
	reg_byte_t   data;
	wire         is_write;
	wire         is_read;
	wire         is_set;
	wire         is_clr;
	wire         is_modify;
	wire         cs_fall;
	wire         avg_evt;
	reg_byte_t   status_clr;
	reg_byte_t   status_set;
	reg_byte_t   next_status;
	reg_byte_t   next_power_down;
	reg_byte_t   next_protocol;
	reg_byte_t   next_resp;
	reg_byte_t   read_value;

	// Implemented bits of a register, zero elsewhere
	function automatic reg_byte_t write_mask(input nibble_t a);
		case (a)
			`ADDR_STATUS_FLAGS: write_mask = `MASK_STATUS_FLAGS;
			`ADDR_POWER_DOWN:   write_mask = `MASK_POWER_DOWN;
			`ADDR_PROTOCOL:     write_mask = `MASK_PROTOCOL;
			default:            write_mask = 8'h00;
		endcase
	endfunction

	// Apply a write, set or clear command to a register
	function automatic reg_byte_t apply_cmd(input reg_byte_t cur, input nibble_t op,
		input reg_byte_t d, input reg_byte_t m);
		case (op)
			`OP_WRITE:      apply_cmd = (cur & ~m) | (d & m);
			`OP_SET_BITS:   apply_cmd = cur | (d & m);
			`OP_CLEAR_BITS: apply_cmd = cur & ~(d & m);
			default:        apply_cmd = cur;
		endcase
	endfunction

	// Reset release through two flops
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	serial_link u_link
	(
		.sclk_i (sclk_i),
		.cs_n_i (cs_n_i),
		.sdi_i  (sdi_i),
		.sdo_o  (sdo_o),
		.nrst_i (nrst_i),
		.lnk    (lnk.link)
	);

	toggle_sync u_frame_sync
	(
		.clk_i   (core_clk_i),
		.rst_n_i (rst_n),
		.ce_i    (ce_i),
		.tgl_i   (lnk.frame_tgl),
		.pulse_o (frame_pulse)
	);

	// Command decode
	assign opcode    = lnk.frame_word[`OPCODE_MSB:`OPCODE_LSB];
	assign addr      = lnk.frame_word[`ADDR_MSB:`ADDR_LSB];
	assign data      = lnk.frame_word[`DATA_MSB:`DATA_LSB];
	assign is_write  = frame_pulse && (opcode == `OP_WRITE);
	assign is_read   = frame_pulse && (opcode == `OP_READ);
	assign is_set    = frame_pulse && (opcode == `OP_SET_BITS);
	assign is_clr    = frame_pulse && (opcode == `OP_CLEAR_BITS);
	assign is_modify = is_write || is_set || is_clr;

	// Chip select falling edge, seen after two flops
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
		end
		else if (ce_i)
		begin
			cs_s1 <= cs_n_i;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
		end
	end

	assign cs_fall = cs_s3 && !cs_s2;
	assign avg_evt = cs_fall && averaging_busy_i;

	// Sticky flags: events win over a write of 1
	assign status_clr  = (is_modify && addr == `ADDR_STATUS_FLAGS) ?
		(data & `MASK_STATUS_FLAGS) : 8'h00;
	assign status_set  = {5'h00, wide_read_zone2_i, avg_evt, 1'b0};
	assign next_status = ((status_flags & ~status_clr) | status_set) & `MASK_STATUS_FLAGS;

	// Reserved bits masked away
	assign next_power_down = (is_modify && addr == `ADDR_POWER_DOWN) ?
		apply_cmd(power_down, opcode, data, write_mask(addr)) : power_down;
	assign next_protocol   = (is_modify && addr == `ADDR_PROTOCOL) ?
		apply_cmd(protocol, opcode, data, write_mask(addr)) : protocol;

	// Read answer held for the next frame
	assign read_value = (addr == `ADDR_STATUS_FLAGS) ? status_flags :
		(addr == `ADDR_POWER_DOWN) ? power_down :
		(addr == `ADDR_PROTOCOL) ? protocol : 8'h00;
	assign next_resp  = is_read ? read_value : (frame_pulse ? 8'h00 : resp);

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_flags <= `RST_STATUS_FLAGS;
			power_down   <= `RST_POWER_DOWN;
			protocol     <= `RST_PROTOCOL;
			resp         <= 8'h00;
		end
		else if (ce_i)
		begin
			status_flags <= next_status;
			power_down   <= next_power_down;
			protocol     <= next_protocol;
			resp         <= next_resp;
		end
	end

	// Protocol family decode
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rt_q  <= 1'b0;
			ddr_q <= 1'b0;
			par_q <= 1'b0;
		end
		else if (ce_i)
		begin
			par_q <= protocol[`PROTO_MSB];
			rt_q  <= !protocol[`PROTO_MSB] && protocol[`PROTO_LSB + 1];
			ddr_q <= !protocol[`PROTO_MSB] && protocol[`PROTO_LSB];
		end
	end

	assign lnk.resp = resp;
	assign lnk.cpol = protocol[`BIT_CLK_POL];
	assign lnk.cpha = protocol[`BIT_CLK_PHASE];

	assign wide_read_late_flag_o        = status_flags[`BIT_WIDE_READ];
	assign averaging_interrupted_flag_o = status_flags[`BIT_AVG_INTR];
	assign half_reference_off_o         = power_down[`BIT_HALF_REF];
	assign second_converter_off_o       = power_down[`BIT_SECOND_CONV];
	assign first_converter_off_o        = power_down[`BIT_FIRST_CONV];
	assign internal_reference_off_o     = power_down[`BIT_INT_REF];
	assign readout_protocol_select_o    = protocol[`PROTO_MSB:`PROTO_LSB];
	assign serial_clock_polarity_o      = protocol[`BIT_CLK_POL];
	assign serial_clock_phase_o         = protocol[`BIT_CLK_PHASE];
	assign retimed_clock_protocol_o     = rt_q;
	assign double_data_rate_o           = ddr_q;
	assign parallel_byte_o              = par_q;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);

	chk_wide_read_set: assert property (
		(ce_i && wide_read_zone2_i) |=> wide_read_late_flag_o)
		else $error("wide read flag not set");

	chk_wide_read_clear: assert property (
		(ce_i && is_modify && !is_clr && addr == `ADDR_STATUS_FLAGS && data[2] && !wide_read_zone2_i)
		|=> !wide_read_late_flag_o)
		else $error("wide read flag not cleared by a 1");

	chk_avg_set: assert property (
		(ce_i && cs_s3 && !cs_s2 && averaging_busy_i) |=> averaging_interrupted_flag_o)
		else $error("averaging flag not set");

	chk_status_zero: assert property (
		(status_flags & ~`MASK_STATUS_FLAGS) == 8'h00)
		else $error("status reserved bit set");

	chk_pd_write: assert property (
		(ce_i && is_write && addr == `ADDR_POWER_DOWN) |=>
		half_reference_off_o == $past(data[5]) && second_converter_off_o == $past(data[3]) &&
		first_converter_off_o == $past(data[1]) && internal_reference_off_o == $past(data[0]))
		else $error("power-down outputs do not follow write");

	chk_reserved_zero: assert property (
		(power_down & 8'hD4) == 8'h00 && (protocol & 8'h8C) == 8'h00)
		else $error("reserved config bit set");

	chk_sticky_hold: assert property (
		(ce_i && is_write && addr == `ADDR_STATUS_FLAGS && !data[1] && !avg_evt)
		|=> averaging_interrupted_flag_o == $past(averaging_interrupted_flag_o))
		else $error("zero write changed sticky flag");

	chk_proto_decode: assert property (
		ce_i ##1 ce_i |-> parallel_byte_o == $past(readout_protocol_select_o[2]) &&
		double_data_rate_o == ($past(readout_protocol_select_o) == 3'h1 ||
		$past(readout_protocol_select_o) == 3'h3) &&
		retimed_clock_protocol_o == ($past(readout_protocol_select_o[2:1]) == 2'h1))
		else $error("protocol decode mismatch");

	chk_read_answer: assert property (
		(ce_i && is_read) |=> resp == $past(read_value) ##1 (!frame_pulse || !ce_i) [*2])
		else $error("read answer not loaded");

	chk_clock_mode: assert property (
		(ce_i && is_write && addr == `ADDR_PROTOCOL) |=>
		lnk.cpol == $past(data[1]) && lnk.cpha == $past(data[0]))
		else $error("clock mode not applied");

	chk_set_bits: assert property (
		(ce_i && is_set && addr == `ADDR_POWER_DOWN) |=>
		power_down == (($past(power_down) | $past(data)) & `MASK_POWER_DOWN))
		else $error("set bits command failed");

	chk_clear_bits: assert property (
		(ce_i && is_clr && addr == `ADDR_POWER_DOWN) |=> (power_down & $past(data)) == 8'h00)
		else $error("clear bits command failed");

	chk_unmapped_read: assert property (
		(ce_i && is_read && addr > `ADDR_PROTOCOL) |=> resp == 8'h00)
		else $error("unmapped read not zero");

	cov_read: cover property (ce_i && is_read ##[1:200] frame_pulse);
	cov_avg: cover property (avg_evt);
	cov_parallel: cover property (parallel_byte_o);
	cov_ddr: cover property (double_data_rate_o && retimed_clock_protocol_o);
endmodule

// file: serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model
(
	// Serial pins
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	logic cpol;
	logic cpha;

	// Late start gives the link flops a real chip-select edge
	initial
	begin
		#1;
		cpol = 1'b0;
		cpha = 1'b0;
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b1;
	end

	// Mode change between frames, clock idles at polarity
	task automatic set_mode(input logic pol, input logic pha);
		cpol = pol;
		cpha = pha;
		sclk_o = pol;
	endtask

	// One frame, MSB first, answer from bit slots 1..8
	task automatic frame(input logic [15:0] cmd, output logic [7:0] ans);
		logic [15:0] rx;
		rx = 16'h0000;
		cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			if (!cpha)
				sdi_o = cmd[i];
			#6;
			if (cpha)
				sdi_o = cmd[i];
			else
				rx = {rx[14:0], sdo_i};
			sclk_o = ~cpol;
			#6;
			if (cpha)
				rx = {rx[14:0], sdo_i};
			sclk_o = cpol;
		end
		#6;
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
		ans = rx[14:7];
	endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`include "adc_regs_cfg.svh"
module testbench;
	import adc_regs_pkg::*;
	logic       core_clk_i;
	logic       nrst_i;
	logic       sclk;
	logic       cs_n;
	logic       sdi;
	logic       sdo;
	logic       wide_i;
	logic       avg_i;
	logic [13:0] outs;
	logic       w_fl, a_fl, hr, sc, fc, ir, pol, pha, ret, ddr, par;
	proto_sel_t proto;
	reg_byte_t  early;
	reg_byte_t  e;
	int         num_errors = 0;
	int         n_compared = 0;

	serial_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));

	adc_status_power_protocol_regs u_dut (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
		.sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo),
		.wide_read_zone2_i(wide_i), .averaging_busy_i(avg_i),
		.wide_read_late_flag_o(w_fl), .averaging_interrupted_flag_o(a_fl),
		.half_reference_off_o(hr), .second_converter_off_o(sc),
		.first_converter_off_o(fc), .internal_reference_off_o(ir),
		.readout_protocol_select_o(proto), .serial_clock_polarity_o(pol),
		.serial_clock_phase_o(pha), .retimed_clock_protocol_o(ret),
		.double_data_rate_o(ddr), .parallel_byte_o(par));

	assign outs = {w_fl, a_fl, hr, sc, fc, ir, pol, pha, ret, ddr, par, proto};

	always #12.5 core_clk_i = ~core_clk_i;

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic gap();
		repeat (12) @(posedge core_clk_i);
		#2;
	endtask

	task automatic wr(input nibble_t op, input nibble_t a, input reg_byte_t d);
		reg_byte_t dummy;
		u_host.frame({op, a, d}, dummy);
		gap();
	endtask

	task automatic cmp_rd(input reg_byte_t got, input reg_byte_t exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_out(input logic [13:0] exp);
		n_compared++;
		if (outs !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t pins %h expected %h", $time, outs, exp);
		end
	endtask

	// Read command, then an idle frame carrying the answer
	task automatic chk_reg(input nibble_t a, input reg_byte_t exp);
		reg_byte_t got;
		u_host.frame({`OP_READ, a, 8'h00}, early);
		gap();
		u_host.frame(16'h0000, got);
		gap();
		cmp_rd(got, exp);
	endtask

	initial
	begin
		#500000;
		num_errors++;
		tally_and_finish();
	end

	initial
	begin
		core_clk_i = 1'b0;
		nrst_i = 1'b1;
		wide_i = 1'b0;
		avg_i = 1'b0;
		#1 nrst_i = 1'b0;
		repeat (4) @(posedge core_clk_i);
		#2 nrst_i = 1'b1;
		gap();
		cmp_out(14'h0000);
		for (int a = 0; a < 3; a++)
			chk_reg(a[3:0], 8'h00);
		$display("test reset done");

		for (int i = 0; i < 8; i++)
		begin
			wr(`OP_WRITE, `ADDR_POWER_DOWN, 8'h01 << i);
			e = (8'h01 << i) & 8'h2B;
			chk_reg(`ADDR_POWER_DOWN, e);
			cmp_out({2'b00, e[5], e[3], e[1], e[0], 8'h00});
		end
		wr(`OP_WRITE, `ADDR_POWER_DOWN, 8'hFF);
		chk_reg(`ADDR_POWER_DOWN, 8'h2B);
		cmp_rd(early, 8'h00);
		wr(`OP_WRITE, `ADDR_POWER_DOWN, 8'h01);
		wr(`OP_SET_BITS, `ADDR_POWER_DOWN, 8'h28);
		chk_reg(`ADDR_POWER_DOWN, 8'h29);
		wr(`OP_CLEAR_BITS, `ADDR_POWER_DOWN, 8'h21);
		chk_reg(`ADDR_POWER_DOWN, 8'h08);
		$display("test power down done");

		for (int p = 0; p < 8; p++)
		begin
			wr(`OP_WRITE, `ADDR_PROTOCOL, {1'b1, p[2:0], 4'hC});
			chk_reg(`ADDR_PROTOCOL, {1'b0, p[2:0], 4'h0});
			cmp_out({6'b000100, 2'b00, p == 2 || p == 3, p == 1 || p == 3, p[2], p[2:0]});
		end
		for (int m = 0; m < 4; m++)
		begin
			wr(`OP_WRITE, `ADDR_PROTOCOL, {6'h00, m[1:0]});
			u_host.set_mode(m[1], m[0]);
			chk_reg(`ADDR_PROTOCOL, {6'h00, m[1:0]});
			cmp_out({6'b000100, m[1:0], 6'h00});
		end
		wr(`OP_WRITE, `ADDR_PROTOCOL, 8'h00);
		u_host.set_mode(1'b0, 1'b0);
		$display("test protocol done");

		@(posedge core_clk_i);
		#2 wide_i = 1'b1;
		@(posedge core_clk_i);
		#2 wide_i = 1'b0;
		wr(`OP_WRITE, `ADDR_STATUS_FLAGS, 8'h00);
		avg_i = 1'b1;
		wr(4'h0, 4'h0, 8'h00);
		avg_i = 1'b0;
		gap();
		cmp_out({6'b110100, 8'h00});
		chk_reg(`ADDR_STATUS_FLAGS, 8'h06);
		wr(`OP_WRITE, `ADDR_STATUS_FLAGS, 8'hFD);
		chk_reg(`ADDR_STATUS_FLAGS, 8'h02);
		wr(`OP_WRITE, `ADDR_STATUS_FLAGS, 8'h02);
		chk_reg(`ADDR_STATUS_FLAGS, 8'h00);
		$display("test status done");

		wr(`OP_WRITE, 4'h3, 8'hFF);
		chk_reg(4'h3, 8'h00);
		chk_reg(4'hF, 8'h00);
		$display("test unmapped done");
		tally_and_finish();
	end
endmodule
